// *** eeprom_pkg.sv ***
package eeprom_pkg;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] ctrl_offset = 8'hf1;
   localparam logic [7:0] ctrl_reset = 8'h00;
   localparam int done_bit = 7;
   localparam int hv_err_bit = 6;
   localparam int mode_hi_bit = 5;
   localparam int mode_lo_bit = 4;
   localparam int blocked_bit = 2;
   localparam int lowv_op_bit = 1;
   localparam int addr_nine_bit = 0;

   // ****************************************
   // array geometry
   // ****************************************
   localparam int array_bytes = 512;
   localparam int row_bytes = 64;
   localparam int addr_w = 9;

   // ****************************************
   // timing
   // ****************************************
   localparam int clock_mhz = 200;
   localparam int prog_time_ms = 4;
   localparam int prog_cycles = prog_time_ms * clock_mhz * 1000;
   localparam int machine_cycle_clocks = 2;
   localparam int read_cycles = 3 * machine_cycle_clocks;

   // ****************************************
   // modes and states
   // ****************************************
   typedef enum logic [1:0] {
      mode_byte = 2'h0,
      mode_rsvd = 2'h1,
      mode_row = 2'h2,
      mode_block = 2'h3
   } op_mode_e;

   typedef enum logic [1:0] {
      st_idle = 2'h0,
      st_read = 2'h1,
      st_prog = 2'h2
   } op_state_e;

   // register write strobes
   typedef struct packed {
      logic addr_wr;
      logic ctrl_wr;
      logic data_wr;
      logic [7:0] wdata;
   } sfr_wr_s;

endpackage

// *** eeprom_array.sv ***
`timescale 1ns/1ps
module eeprom_array #(
   parameter int depth = 512,
   parameter int aw = 9
) (
   // clocking
   input wire logic clock,
   input wire logic clk_en,
   // access
   input wire logic wr_en,
   input wire logic [aw-1:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [aw-1:0] rd_addr,
   output logic [7:0] rd_data
);

   // no reset: contents are nonvolatile in spirit
   logic [7:0] mem [depth];

   // synchronous write and registered read
   always_ff @(posedge clock) begin
      if (clk_en) begin
         if (wr_en) begin
            mem[wr_addr] <= wr_data;
         end
         rd_data <= mem[rd_addr];
      end
   end

endmodule

// *** data_eeprom_controller.sv ***
`timescale 1ns/1ps
// Operation
// R1: 512 bytes, nine-bit address, bit nine in control
// R2: mode field selects byte, row, block
// R3: data register holds write byte, read result
// R4: read data ready three machine cycles later
// R5: write and fills take about 4 ms
// R6: row fill programs 64 bytes, low bits ignored
// R7: block fill programs all 512 bytes
// R8: software sets bit nine before block fill
// R9: done flag set on finish, software clears
// R10: interrupt when done, both enables set
// R11: low supply blocks program, sets blocked flag
// R12: low supply mid-operation sets corruption flag
// R13: supply flags cleared by reset or write
// R14: voltage fault during program sets flag
// R15: data then address write starts byte write
// R16: hardware reset clears pending data write
// R17: latest data write is programmed
// R18: block fill ignores the address register
// R19: address writes ignored while busy
module data_eeprom_controller #(
   parameter int prog_cycles = eeprom_pkg::prog_cycles
) (
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   input wire logic clk_en,
   // special function register bus
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic addr_wr,
   input wire logic ctrl_wr,
   input wire logic data_wr,
   output logic [7:0] eeprom_addr_reg,
   output logic [7:0] eeprom_ctrl_reg,
   output logic [7:0] eeprom_data_reg,
   // supply monitors
   input wire logic brownout_detector,
   input wire logic prog_voltage_fault,
   // interrupt enables and request
   input wire logic eeprom_irq_enable,
   input wire logic global_irq_enable,
   output logic irq_req,
   // status
   output logic busy
);

   // ****************************************
   // register state
   // ****************************************
   logic op_done_flag;
   logic prog_voltage_error_flag;
   logic lowv_blocked_flag;
   logic lowv_during_op_flag;
   logic addr_bit_nine;
   logic [1:0] op_mode_sel;
   logic data_pending_reg;
   eeprom_pkg::op_state_e state_reg;
   logic [31:0] count_reg;
   logic [8:0] fill_ptr_reg;
   logic [8:0] fill_end_reg;
   logic [8:0] op_addr_reg;
   logic [7:0] rd_data;
   logic arr_wr;
   logic [8:0] arr_addr;
   logic ctrl_sel;
   logic start;
   logic start_prog;
   logic done_evt;
   logic prog_last;
   eeprom_pkg::sfr_wr_s wr;

   // ****************************************
   // decode helpers
   // ****************************************
   // true while the sequencer is programming the array
   function automatic logic in_prog(input eeprom_pkg::op_state_e s);
      return (s == eeprom_pkg::st_prog);
   endfunction

   // last cycle of a read: result and done flag are taken together
   function automatic logic read_last(input eeprom_pkg::op_state_e s, input logic [31:0] c);
      return (s == eeprom_pkg::st_read) && (c == 32'h0);
   endfunction

   // bundle the incoming strobes
   assign wr = '{addr_wr: addr_wr, ctrl_wr: ctrl_wr, data_wr: data_wr, wdata: sfr_wdata};

   // control strobe is also qualified by its own offset;
   // other offsets belong to other registers on the shared bus
   assign ctrl_sel = wr.ctrl_wr && (sfr_addr == eeprom_pkg::ctrl_offset);

   // address write is a trigger only while idle; a second trigger
   // while busy would otherwise retarget a fill half way through
   assign start = clk_en && wr.addr_wr && (state_reg == eeprom_pkg::st_idle); // R19

   // any non-read operation programs the array
   assign start_prog = start && ((op_mode_sel != eeprom_pkg::mode_byte) || data_pending_reg); // R15

   // last programmed cycle of an operation; done and idle land together
   assign prog_last = in_prog(state_reg) && (count_reg == 32'h0);

   // completion of any operation, including a blocked one, so that
   // software polling the done flag never waits forever
   assign done_evt = read_last(state_reg, count_reg) || prog_last ||
                     (start_prog && brownout_detector);

   // ****************************************
   // control register
   // ****************************************
   assign eeprom_ctrl_reg = {op_done_flag, prog_voltage_error_flag, op_mode_sel, 1'b0,
                             lowv_blocked_flag, lowv_during_op_flag, addr_bit_nine};

   // software fields: mode and address bit nine
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         op_mode_sel <= eeprom_pkg::ctrl_reset[eeprom_pkg::mode_hi_bit:eeprom_pkg::mode_lo_bit];
         addr_bit_nine <= eeprom_pkg::ctrl_reset[eeprom_pkg::addr_nine_bit];
      end else if (clk_en && ctrl_sel) begin
         op_mode_sel <= wr.wdata[eeprom_pkg::mode_hi_bit:eeprom_pkg::mode_lo_bit]; // R2
         addr_bit_nine <= wr.wdata[eeprom_pkg::addr_nine_bit]; // R1
      end
   end

   // done flag: set wins over a software clear
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         op_done_flag <= 1'b0;
      end else if (clk_en) begin
         if (done_evt) begin
            op_done_flag <= 1'b1; // R9
         end else if (ctrl_sel && !wr.wdata[eeprom_pkg::done_bit]) begin
            op_done_flag <= 1'b0; // R9
         end
      end
   end

   // voltage fault flag, cleared by writing zero;
   // a fault seen while idle is no programming error and is ignored
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         prog_voltage_error_flag <= 1'b0;
      end else if (clk_en) begin
         if (in_prog(state_reg) && prog_voltage_fault) begin
            prog_voltage_error_flag <= 1'b1; // R14
         end else if (ctrl_sel && !wr.wdata[eeprom_pkg::hv_err_bit]) begin
            prog_voltage_error_flag <= 1'b0;
         end
      end
   end

   // supply flags: any control write clears, a new event wins;
   // they only report, a running fill is not stopped by them
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         lowv_blocked_flag <= 1'b0; // R13
         lowv_during_op_flag <= 1'b0; // R13
      end else if (clk_en) begin
         if (start_prog && brownout_detector) begin
            lowv_blocked_flag <= 1'b1; // R11
         end else if (ctrl_sel) begin
            lowv_blocked_flag <= 1'b0; // R13
         end
         if (in_prog(state_reg) && brownout_detector) begin
            lowv_during_op_flag <= 1'b1; // R12
         end else if (ctrl_sel) begin
            lowv_during_op_flag <= 1'b0; // R13
         end
      end
   end

   // interrupt request is a level that follows the flag, so clearing
   // the flag or dropping either enable withdraws it
   assign irq_req = op_done_flag && eeprom_irq_enable && global_irq_enable; // R10

   // ****************************************
   // address and data registers
   // ****************************************
   // address register keeps only accepted triggers
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         eeprom_addr_reg <= 8'h00;
      end else if (start) begin
         eeprom_addr_reg <= wr.wdata;
      end
   end

   // pending write memory: only in byte mode, dropped by reset;
   // a data write while busy is ignored so it cannot arm a later write
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         data_pending_reg <= 1'b0; // R16
      end else if (clk_en) begin
         if (start) begin
            data_pending_reg <= 1'b0;
         end else if (wr.data_wr && op_mode_sel == eeprom_pkg::mode_byte &&
                      state_reg == eeprom_pkg::st_idle) begin
            data_pending_reg <= 1'b1; // R15
         end
      end
   end

   // data register: software byte, replaced by read result
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         eeprom_data_reg <= 8'h00;
      end else if (clk_en) begin
         if (read_last(state_reg, count_reg)) begin
            eeprom_data_reg <= rd_data; // R3
         end else if (wr.data_wr && state_reg == eeprom_pkg::st_idle) begin
            eeprom_data_reg <= wr.wdata; // R17
         end
      end
   end

   // ****************************************
   // operation sequencer
   // ****************************************
   // programming is spread over the whole program time so the array
   // model sees one write per step; the pattern stays frozen while busy
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_reg <= eeprom_pkg::st_idle;
         count_reg <= 32'h0;
         fill_ptr_reg <= 9'h000;
         fill_end_reg <= 9'h000;
         op_addr_reg <= 9'h000;
      end else if (clk_en) begin
         case (state_reg)
            eeprom_pkg::st_idle: begin
               if (start && !start_prog) begin
                  state_reg <= eeprom_pkg::st_read;
                  op_addr_reg <= {addr_bit_nine, wr.wdata}; // R1
                  // counts down to zero, so the result lands on the sixth edge
                  count_reg <= 32'(eeprom_pkg::read_cycles - 1); // R4
               end else if (start_prog && !brownout_detector) begin // R11
                  state_reg <= eeprom_pkg::st_prog;
                  count_reg <= 32'(prog_cycles - 1); // R5
                  // reserved mode falls to the default and programs one byte
                  case (op_mode_sel)
                     eeprom_pkg::mode_row: begin
                        fill_ptr_reg <= {addr_bit_nine, wr.wdata[7:6], 6'h00}; // R6
                        fill_end_reg <= {addr_bit_nine, wr.wdata[7:6], 6'h3f}; // R6
                     end
                     // block fill ignores both the address byte and bit nine
                     eeprom_pkg::mode_block: begin
                        fill_ptr_reg <= 9'h000; // R18
                        fill_end_reg <= 9'h1ff; // R7
                     end
                     default: begin
                        fill_ptr_reg <= {addr_bit_nine, wr.wdata}; // R15
                        fill_end_reg <= {addr_bit_nine, wr.wdata};
                     end
                  endcase
               end
            end
            eeprom_pkg::st_read: begin
               if (count_reg == 32'h0) begin
                  state_reg <= eeprom_pkg::st_idle;
               end else begin
                  count_reg <= count_reg - 32'h1;
               end
            end
            eeprom_pkg::st_prog: begin
               // the pointer parks on the last byte and rewrites it until time runs out
               if (fill_ptr_reg != fill_end_reg) begin
                  fill_ptr_reg <= fill_ptr_reg + 9'h001; // R7
               end
               if (count_reg == 32'h0) begin
                  state_reg <= eeprom_pkg::st_idle; // R5
               end else begin
                  count_reg <= count_reg - 32'h1;
               end
            end
            default: begin
               state_reg <= eeprom_pkg::st_idle;
            end
         endcase
      end
   end

   // one byte per cycle until the range is covered, then the last byte again on every cycle but the final one
   assign arr_wr = in_prog(state_reg) &&
                   ((fill_ptr_reg != fill_end_reg) || (count_reg == 32'(prog_cycles - 1)) ||
                    (fill_ptr_reg == fill_end_reg && !prog_last && count_reg != 32'h0));
   assign arr_addr = in_prog(state_reg) ? fill_ptr_reg : op_addr_reg;

   // busy covers reads too, so software can poll one signal
   assign busy = (state_reg != eeprom_pkg::st_idle);

   // ****************************************
   // storage array
   // ****************************************
   // writes come only from the fill pointer; reads use the latched address
   eeprom_array #(
      .depth(eeprom_pkg::array_bytes),
      .aw(eeprom_pkg::addr_w)
   ) u_array (
      .clock(clock),
      .clk_en(clk_en),
      .wr_en(arr_wr),
      .wr_addr(fill_ptr_reg),
      .wr_data(eeprom_data_reg),
      .rd_addr(arr_addr),
      .rd_data(rd_data)
   );

endmodule

// *** sfr_host.sv ***
`timescale 1ns/1ps
module sfr_host (
   // clock
   input wire logic clock,
   // register bus toward the block
   output logic [7:0] sfr_addr,
   output logic [7:0] sfr_wdata,
   output logic addr_wr,
   output logic ctrl_wr,
   output logic data_wr
);
   // ****************************************
   // core side of the register bus
   // ****************************************
   // idle bus: strobes low before the first write
   initial begin
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      addr_wr = 1'b0;
      ctrl_wr = 1'b0;
      data_wr = 1'b0;
   end
   // kind 0 address, 1 control, 2 data; strobe lasts exactly one cycle
   task automatic put(input logic [1:0] kind, input logic [7:0] d);
      @(posedge clock);
      sfr_addr <= (kind == 2'h1) ? eeprom_pkg::ctrl_offset : 8'h00;
      sfr_wdata <= d;
      addr_wr <= (kind == 2'h0);
      ctrl_wr <= (kind == 2'h1);
      data_wr <= (kind == 2'h2);
      @(posedge clock);
      addr_wr <= 1'b0;
      ctrl_wr <= 1'b0;
      data_wr <= 1'b0;
      sfr_wdata <= ~d; // stale data must never pass for fresh
   endtask
endmodule

// *** data_eeprom_controller_checker.sv ***
`timescale 1ns/1ps
module data_eeprom_controller_checker #(
   parameter int prog_cycles = 600
) (
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   input wire logic clk_en,
   // register bus
   input wire logic addr_wr,
   input wire logic ctrl_wr,
   input wire logic [7:0] eeprom_addr_reg,
   input wire logic [7:0] eeprom_ctrl_reg,
   // supply, interrupt, status
   input wire logic brownout_detector,
   input wire logic prog_voltage_fault,
   input wire logic eeprom_irq_enable,
   input wire logic global_irq_enable,
   input wire logic irq_req,
   input wire logic busy
);
   // ****************************************
   // properties
   // ****************************************
   localparam int fill_wait = prog_cycles;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   // a fill starts, then ends with done after the full programming time
   sequence fill_start;
      $rose(busy) && eeprom_ctrl_reg[5];
   endsequence
   sequence op_end;
      !busy && eeprom_ctrl_reg[7];
   endsequence
   start_op_a: assert property (addr_wr && clk_en && !busy && !brownout_detector |=> busy)
      else $error("idle trigger did not start an operation");
   addr_hold_a: assert property (busy && addr_wr |=> $stable(eeprom_addr_reg))
      else $error("address taken while busy");
   irq_level_a: assert property (irq_req == (eeprom_ctrl_reg[7] && eeprom_irq_enable
      && global_irq_enable))
      else $error("interrupt request disagrees with flag and enables");
   done_on_end_a: assert property ($fell(busy) |-> eeprom_ctrl_reg[7])
      else $error("operation ended without done flag");
   done_sticky_a: assert property (eeprom_ctrl_reg[7] && !ctrl_wr |=> eeprom_ctrl_reg[7])
      else $error("done flag dropped without a write");
   fill_time_a: assert property (fill_start |-> ##[fill_wait:fill_wait] op_end)
      else $error("fill did not last the programming time");
   blocked_flag_a: assert property (addr_wr && clk_en && !busy && brownout_detector
      && eeprom_ctrl_reg[5] |=> eeprom_ctrl_reg[2] && !busy)
      else $error("low supply request not blocked");
   lowv_flag_a: assert property (busy && clk_en && brownout_detector && eeprom_ctrl_reg[5]
      |=> eeprom_ctrl_reg[1])
      else $error("low supply during fill not flagged");
   hv_flag_a: assert property (busy && clk_en && prog_voltage_fault && eeprom_ctrl_reg[5]
      |=> eeprom_ctrl_reg[6])
      else $error("voltage fault during fill not flagged");
endmodule
bind data_eeprom_controller data_eeprom_controller_checker #(.prog_cycles(prog_cycles)) chk (
   .clock(clock), .nrst(nrst), .clk_en(clk_en), .addr_wr(addr_wr), .ctrl_wr(ctrl_wr),
   .eeprom_addr_reg(eeprom_addr_reg), .eeprom_ctrl_reg(eeprom_ctrl_reg),
   .brownout_detector(brownout_detector), .prog_voltage_fault(prog_voltage_fault),
   .eeprom_irq_enable(eeprom_irq_enable), .global_irq_enable(global_irq_enable),
   .irq_req(irq_req), .busy(busy));

// *** data_eeprom_controller_tb.sv ***
`timescale 1ns/1ps
module data_eeprom_controller_tb;
   // ****************************************
   // bench
   // ****************************************
   logic clock, nrst, clk_en, brownout_detector, prog_voltage_fault;
   logic eeprom_irq_enable, global_irq_enable, addr_wr, ctrl_wr, data_wr, irq_req, busy;
   logic [7:0] sfr_addr, sfr_wdata, eeprom_addr_reg, eeprom_ctrl_reg, eeprom_data_reg;
   int mismatches = 0;
   int checked = 0;
   // short programming time keeps the run small; must exceed 512
   data_eeprom_controller #(.prog_cycles(600)) dut (.clock(clock), .nrst(nrst),
      .clk_en(clk_en), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .addr_wr(addr_wr),
      .ctrl_wr(ctrl_wr), .data_wr(data_wr), .eeprom_addr_reg(eeprom_addr_reg),
      .eeprom_ctrl_reg(eeprom_ctrl_reg), .eeprom_data_reg(eeprom_data_reg),
      .brownout_detector(brownout_detector), .prog_voltage_fault(prog_voltage_fault),
      .eeprom_irq_enable(eeprom_irq_enable), .global_irq_enable(global_irq_enable),
      .irq_req(irq_req), .busy(busy));
   sfr_host host (.clock(clock), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
      .addr_wr(addr_wr), .ctrl_wr(ctrl_wr), .data_wr(data_wr));
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic test_done;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // bounded wait for busy to drop; a hang shows as a mismatch
   task automatic wait_idle;
      int n;
      n = 0;
      do begin
         @(posedge clock);
         #1;
         n++;
      end while (busy !== 1'b0 && n < 800);
      check("idle", {7'h00, busy}, 8'h00);
   endtask
   // byte read; result must appear exactly six clocks after the address edge
   task automatic read_at(input logic [8:0] a, input logic [7:0] exp);
      host.put(2'h1, {7'h00, a[8]});
      host.put(2'h0, a[7:0]);
      repeat (5) @(posedge clock);
      #1;
      check("early", eeprom_ctrl_reg, {7'h00, a[8]});
      check("rbusy", {7'h00, busy}, 8'h01);
      @(posedge clock);
      #1;
      check("rdata", eeprom_data_reg, exp);
      check("rdone", eeprom_ctrl_reg, {1'b1, 6'h00, a[8]});
      wait_idle;
   endtask
   task automatic fill(input logic [7:0] ctl, input logic [7:0] pat, input logic [7:0] a);
      host.put(2'h1, ctl);
      host.put(2'h2, pat);
      host.put(2'h0, a);
   endtask
   task automatic t_byte;
      check("ctrl0", eeprom_ctrl_reg, eiprom_reset());
      check("addr0", eeprom_addr_reg, 8'h00);
      check("data0", eeprom_data_reg, 8'h00);
      host.put(2'h1, 8'h01);
      host.put(2'h2, 8'h11);
      fill(8'h01, 8'h5a, 8'h23);
      wait_idle;
      check("wdone", eeprom_ctrl_reg, 8'h81);
      check("irq_on", {7'h00, irq_req}, 8'h01);
      @(posedge clock);
      global_irq_enable <= 1'b0;
      #1;
      check("irq_off", {7'h00, irq_req}, 8'h00);
      @(posedge clock);
      global_irq_enable <= 1'b1;
      eeprom_irq_enable <= 1'b0;
      #1;
      check("irq_en_off", {7'h00, irq_req}, 8'h00);
      @(posedge clock);
      eeprom_irq_enable <= 1'b1;
      #1;
      check("irq_back", {7'h00, irq_req}, 8'h01);
      read_at(9'h123, 8'h5a);
      $display("byte test done");
   endtask
   function automatic logic [7:0] eiprom_reset();
      return eeprom_pkg::ctrl_reset;
   endfunction
   task automatic t_row;
      fill(8'h20, 8'hc3, 8'h47);
      wait_idle;
      check("rowdone", eeprom_ctrl_reg, 8'ha0);
      read_at(9'h040, 8'hc3);
      read_at(9'h07f, 8'hc3);
      read_at(9'h123, 8'h5a);
      $display("row test done");
   endtask
   task automatic t_supply;
      fill(8'h20, 8'h3c, 8'h80);
      host.put(2'h0, 8'h99);
      #1;
      check("addrhold", eeprom_addr_reg, 8'h80);
      repeat (10) @(posedge clock);
      brownout_detector <= 1'b1;
      prog_voltage_fault <= 1'b1;
      repeat (3) @(posedge clock);
      brownout_detector <= 1'b0;
      prog_voltage_fault <= 1'b0;
      wait_idle;
      check("faults", eeprom_ctrl_reg, 8'he2);
      host.put(2'h1, 8'h20);
      brownout_detector <= 1'b1;
      #1;
      check("clear1", eeprom_ctrl_reg, 8'h20);
      host.put(2'h0, 8'h80);
      wait_idle;
      check("blocked", eeprom_ctrl_reg, 8'ha4);
      @(posedge clock);
      brownout_detector <= 1'b0;
      host.put(2'h1, 8'h20);
      #1;
      check("clear2", eeprom_ctrl_reg, 8'h20);
      @(posedge clock);
      clk_en <= 1'b0;
      host.put(2'h1, 8'h31);
      clk_en <= 1'b1;
      #1;
      check("frozen", eeprom_ctrl_reg, 8'h20);
      $display("supply test done");
   endtask
   task automatic t_block;
      fill(8'h31, 8'h96, 8'h00);
      wait_idle;
      check("blkdone", eeprom_ctrl_reg, 8'hb1);
      read_at(9'h000, 8'h96);
      read_at(9'h1ff, 8'h96);
      read_at(9'h0a5, 8'h96);
      $display("block test done");
   endtask
   // pending data write must not survive a reset: next address write reads
   task automatic t_reset;
      host.put(2'h1, 8'h01);
      host.put(2'h2, 8'h77);
      nrst <= 1'b0;
      repeat (3) @(posedge clock);
      nrst <= 1'b1;
      #1;
      check("rstctrl", eeprom_ctrl_reg, 8'h00);
      read_at(9'h123, 8'h96);
      $display("reset test done");
   endtask
   // free running clock
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   // watchdog sized for well under ten thousand cycles of work
   initial begin
      #200000;
      mismatches++;
      test_done;
   end
   initial begin
      nrst = 1'b0;
      clk_en = 1'b1;
      brownout_detector = 1'b0;
      prog_voltage_fault = 1'b0;
      eeprom_irq_enable = 1'b1;
      global_irq_enable = 1'b1;
      repeat (20) @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
      t_byte;
      t_row;
      t_supply;
      t_block;
      t_reset;
      test_done;
   end
endmodule
